//--- rom_gw_model.sv
// gateway controller model issuing one action at a time
`timescale 1ns/1ps
`default_nettype none
module rom_gw_model (
  input  wire logic              clk_i,
  input  wire logic              ready_i,
  input  wire logic              rsp_valid_i,
  input  wire logic [7:0]        rsp_data_i,
  input  wire rom_pkg::rom_err_t rsp_err_i,
  output logic                   valid_o,
  output rom_pkg::rom_op_t       op_o,
  output logic                   ok_o,
  output logic [7:0]             data_o
);
  initial begin
    valid_o = 0; op_o = 3'h7; ok_o = 0; data_o = 8'hA5;
  end
  task automatic exec(input rom_pkg::rom_op_t op, input logic ok, input logic [7:0] d,
                      input int w, output logic [7:0] rd, output rom_pkg::rom_err_t re,
                      output bit to);
    bit got;
    to = 1; got = 0;
    // every request leaves at the same offset after an edge
    repeat (w + 1) @(posedge clk_i);
    #1 valid_o = 1; op_o = op; ok_o = ok; data_o = d;
    for (int i = 0; i < 9 && to; i++) begin @(posedge clk_i); to = !ready_i; end
    #1 valid_o = 0; op_o = ~op; ok_o = ~ok; data_o = ~d;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge clk_i);
      got = rsp_valid_i; rd = rsp_data_i; re = rsp_err_i;
    end
    to = to | !got;
  endtask : exec
endmodule : rom_gw_model
`default_nettype wire

//--- rom_map.svh
// constants for the relay output monitor: encodings, timing and reset values
`ifndef ROM_MAP_SVH
`define ROM_MAP_SVH
`define ROM_CLK_MHZ          100
`define ROM_SAMPLE_PERIOD_MS 2
`define ROM_SAMPLE_CYCLES    (`ROM_SAMPLE_PERIOD_MS * 1000 * `ROM_CLK_MHZ)
`define ROM_STATES_RST       8'h00
`define ROM_STAT_DRVR_BIT    0
`define ROM_STAT_STRM_BIT    1
`define ROM_STAT_RST_BIT     2
`define ROM_STAT_CERR_BIT    3
`define ROM_ERR_NONE         2'h0
`define ROM_ERR_TYPE         2'h1
`define ROM_ERR_SPECIFIC     2'h2
`define ROM_OP_SET_OUTPUTS   3'h1
`define ROM_OP_GET_OUTPUTS   3'h2
`define ROM_OP_GET_INPUTS    3'h3
`define ROM_OP_CLEAR_FLAGS   3'h4
`define ROM_OP_GET_STATUS    3'h5
`endif

//--- rom_pkg.sv
// types shared by the relay output monitor modules
`default_nettype none
package rom_pkg;
  typedef logic [2:0] rom_op_t;
  typedef logic [1:0] rom_err_t;
  typedef enum logic [2:0] {
    ROM_IDLE = 3'b001,
    ROM_EXEC = 3'b010,
    ROM_RESP = 3'b100
  } rom_state_e;
endpackage : rom_pkg
`default_nettype wire

//--- rom_relay_monitor.sv
// eight-channel relay output module: action port, drive register, status flags
// Function
// - bit n is channel n, one active
// - set-outputs writes all eight drives
// - get-outputs returns programmed drive byte
// - get-inputs returns monitored coil-driver states
// - monitor states sampled every two milliseconds
// - wrong module type rejected with error
// - driver fault, stream error flags; clear-flags
// - driver fault or stream flag gives module-specific error
`timescale 1ns/1ps
`default_nettype none
`include "rom_map.svh"
module rom_relay_monitor #(
  parameter int N             = 8,
  parameter int SAMPLE_CYCLES = `ROM_SAMPLE_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             act_valid_i,
  output logic                  act_ready_o,
  input  wire rom_pkg::rom_op_t act_op_i,
  input  wire logic             act_type_ok_i,
  input  wire logic [N-1:0]     act_data_i,
  output logic                  rsp_valid_o,
  output logic [N-1:0]          rsp_data_o,
  output rom_pkg::rom_err_t     rsp_err_o,
  output logic [3:0]            rsp_status_o,
  input  wire logic [N-1:0]     coil_mon_i,
  input  wire logic             stream_err_i,
  input  wire logic             link_comm_err_i,
  output logic [N-1:0]          relay_drive_o
);
  // ==========================================================
  // sampler
  rom_sample_if #(.N(N)) smp_if ();
  rom_sampler #(.N(N), .PERIOD(SAMPLE_CYCLES)) u_smp (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .mon_i  (coil_mon_i),
    .smp    (smp_if.sampler)
  );

  // ==========================================================
  // state
  rom_pkg::rom_state_e state_r;
  rom_pkg::rom_op_t    op_r;
  logic [N-1:0]        wdata_r;
  logic                type_ok_r;
  logic [N-1:0]        drive_r;
  logic                drvr_flag_r;
  logic                strm_flag_r;
  logic                rst_flag_r;
  logic                cerr_flag_r;
  logic [N-1:0]        rsp_data_r;
  rom_pkg::rom_err_t   rsp_err_r;
  logic                clr_now;
  logic                exec_now;
  logic [N-1:0]        drive_q_r;
  logic [N-1:0]        chan_miss;
  logic                fault_now;
  logic [3:0]          status_w;

  function automatic logic is_op(input rom_pkg::rom_op_t a, input rom_pkg::rom_op_t b);
    is_op = (a == b);
  endfunction : is_op

  assign act_ready_o = (state_r == rom_pkg::ROM_IDLE);
  assign exec_now    = (state_r == rom_pkg::ROM_EXEC);
  assign clr_now     = exec_now && type_ok_r && is_op(op_r, `ROM_OP_CLEAR_FLAGS);

  // ==========================================================
  // action sequencer: only a taken action acts
  // act only on executed actions
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= rom_pkg::ROM_IDLE;
    end else begin
      case (state_r)
        rom_pkg::ROM_IDLE: begin
          if (act_valid_i) begin
            state_r <= rom_pkg::ROM_EXEC;
          end
        end
        rom_pkg::ROM_EXEC: state_r <= rom_pkg::ROM_RESP;
        rom_pkg::ROM_RESP: state_r <= rom_pkg::ROM_IDLE;
        default:           state_r <= rom_pkg::ROM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_r      <= 3'h0;
      wdata_r   <= '0;
      type_ok_r <= 1'b0;
    end else if (act_valid_i && act_ready_o) begin
      op_r      <= act_op_i;
      wdata_r   <= act_data_i;
      type_ok_r <= act_type_ok_i;
    end
  end

  // ==========================================================
  // drive register
  // drives inactive after reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drive_r <= N'(`ROM_STATES_RST);
    end else if (exec_now && type_ok_r && is_op(op_r, `ROM_OP_SET_OUTPUTS)) begin
      drive_r <= wdata_r;
    end
  end
  assign relay_drive_o = drive_r;

  // drive as the monitor lines saw it at the sample edge, so a fresh write is no fault
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drive_q_r <= N'(`ROM_STATES_RST);
    end else begin
      drive_q_r <= drive_r;
    end
  end

  // ==========================================================
  // per-channel coil-driver check
  // channel differs from drive
  for (genvar ch = 0; ch < N; ch++) begin : g_chan
    assign chan_miss[ch] = smp_if.sampled[ch] ^ drive_q_r[ch];
  end
  // only a fresh sample may raise the fault
  assign fault_now = smp_if.tick && (|chan_miss);

  // ==========================================================
  // status flags, set wins over clear
  // driver fault on mismatch at sample
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drvr_flag_r <= 1'b0;
    end else if (fault_now) begin
      drvr_flag_r <= 1'b1;
    end else if (clr_now) begin
      drvr_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strm_flag_r <= 1'b0;
    end else if (stream_err_i) begin
      strm_flag_r <= 1'b1;
    end else if (clr_now) begin
      strm_flag_r <= 1'b0;
    end
  end

  // reset flag: raised by reset, dropped by clear-flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_flag_r <= 1'b1;
    end else if (clr_now) begin
      rst_flag_r <= 1'b0;
    end
  end

  // link error flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cerr_flag_r <= 1'b0;
    end else if (link_comm_err_i) begin
      cerr_flag_r <= 1'b1;
    end else if (clr_now) begin
      cerr_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // response
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rsp_data_r <= '0;
      rsp_err_r  <= `ROM_ERR_NONE;
    end else if (exec_now) begin
      rsp_data_r <= '0;
      rsp_err_r  <= `ROM_ERR_NONE;
      if (!type_ok_r) begin
        rsp_err_r <= `ROM_ERR_TYPE;
      end else begin
        if (drvr_flag_r || strm_flag_r) begin
          rsp_err_r <= `ROM_ERR_SPECIFIC;
        end
        if (is_op(op_r, `ROM_OP_GET_OUTPUTS)) begin
          rsp_data_r <= drive_r;
        end
        if (is_op(op_r, `ROM_OP_GET_INPUTS)) begin
          rsp_data_r <= smp_if.sampled;
        end
      end
    end
  end

  assign rsp_valid_o = (state_r == rom_pkg::ROM_RESP);
  assign rsp_data_o  = rsp_data_r;
  assign rsp_err_o   = rsp_err_r;
  // status word, one flag per bit
  always_comb begin
    status_w                     = 4'h0;
    status_w[`ROM_STAT_DRVR_BIT] = drvr_flag_r;
    status_w[`ROM_STAT_STRM_BIT] = strm_flag_r;
    status_w[`ROM_STAT_RST_BIT]  = rst_flag_r;
    status_w[`ROM_STAT_CERR_BIT] = cerr_flag_r;
  end
  assign rsp_status_o = status_w;
endmodule : rom_relay_monitor
`default_nettype wire

//--- rom_relay_monitor_sva.sv
// port assertions for the relay output monitor
`timescale 1ns/1ps
`default_nettype none
`include "rom_map.svh"
module rom_relay_monitor_sva #(parameter int N = 8) (
  input wire logic clk_i, srst_i, act_valid_i, act_ready_o, act_type_ok_i,
  input wire rom_pkg::rom_op_t act_op_i,
  input wire logic [N-1:0] act_data_i, rsp_data_o, coil_mon_i, relay_drive_o,
  input wire logic rsp_valid_o, stream_err_i, link_comm_err_i,
  input wire rom_pkg::rom_err_t rsp_err_o,
  input wire logic [3:0] rsp_status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire t = act_valid_i & act_ready_o;
  wire g = t & act_type_ok_i;
  property p_rsp; t |=> !act_ready_o ##1 rsp_valid_o ##1 (act_ready_o && !rsp_valid_o); endproperty
  a_rsp: assert property (p_rsp) else $error("answer timing");
  property p_set; g && act_op_i == `ROM_OP_SET_OUTPUTS |-> ##2 relay_drive_o == $past(act_data_i, 2); endproperty
  a_set: assert property (p_set) else $error("drive byte");
  property p_get; g && act_op_i == `ROM_OP_GET_OUTPUTS |-> ##2 rsp_data_o == relay_drive_o; endproperty
  a_get: assert property (p_get) else $error("programmed byte");
  property p_type; t && !act_type_ok_i |=> $stable(relay_drive_o) ##1
    (rsp_err_o == `ROM_ERR_TYPE && $stable(relay_drive_o)); endproperty
  a_type: assert property (p_type) else $error("wrong type");
  property p_spec; g && rsp_status_o[1:0] != 2'h0 |-> ##2 rsp_err_o == `ROM_ERR_SPECIFIC; endproperty
  a_spec: assert property (p_spec) else $error("specific error");
  property p_clr; g && act_op_i == `ROM_OP_CLEAR_FLAGS ##1 !stream_err_i |=> !rsp_status_o[1]; endproperty
  a_clr: assert property (p_clr) else $error("flag clear");
  property p_strm; stream_err_i |=> rsp_status_o[1]; endproperty
  a_strm: assert property (p_strm) else $error("stream flag");
  property p_rst; disable iff (1'b0) srst_i |=> relay_drive_o == `ROM_STATES_RST && !rsp_valid_o; endproperty
  a_rst: assert property (p_rst) else $error("reset drives");
endmodule : rom_relay_monitor_sva
`default_nettype wire

//--- rom_sample_if.sv
// carrier between the top and the sampler
`timescale 1ns/1ps
`default_nettype none
interface rom_sample_if #(parameter int N = 8);
  logic [N-1:0] sampled;
  logic         tick;
  modport sampler (output sampled, output tick);
  modport user    (input sampled, input tick);
endinterface : rom_sample_if
`default_nettype wire

//--- rom_sampler.sv
// periodic sampler of the coil-driver monitor lines
`timescale 1ns/1ps
`default_nettype none
`include "rom_map.svh"
module rom_sampler #(
  parameter int N      = 8,
  parameter int PERIOD = `ROM_SAMPLE_CYCLES
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [N-1:0] mon_i,
  rom_sample_if.sampler     smp
);
  logic [31:0]  cnt_r;
  logic [N-1:0] smp_r;
  logic         tick_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      smp_r <= '0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      smp_r <= mon_i;
    end
  end
  assign smp.sampled = smp_r;
  assign smp.tick    = tick_r;
endmodule : rom_sampler
`default_nettype wire

//--- tb_top.sv
// testbench for the relay output monitor
`timescale 1ns/1ps
`default_nettype none
`include "rom_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam int SMP = 20;
  logic clk_i = 0, srst_i = 1, strm = 0, cerr = 0, valid, ready, ok, rv, k;
  logic [7:0] mask = 0, drv, mon, dat, data, rd, d, xd = 0;
  rom_pkg::rom_op_t op, o;
  rom_pkg::rom_err_t re, err;
  logic [3:0] st;
  int fail_count = 0, cmp_count = 0;
  bit to;
  always #5 clk_i = ~clk_i;
  assign mon = drv ^ mask;
  rom_relay_monitor #(.SAMPLE_CYCLES(SMP)) rom_relay_monitor_inst (.clk_i, .srst_i,
    .act_valid_i(valid), .act_ready_o(ready), .act_op_i(op), .act_type_ok_i(ok),
    .act_data_i(data), .rsp_valid_o(rv), .rsp_data_o(dat), .rsp_err_o(err),
    .rsp_status_o(st), .coil_mon_i(mon), .stream_err_i(strm), .link_comm_err_i(cerr),
    .relay_drive_o(drv));
  rom_gw_model rom_gw_model_inst (.clk_i, .ready_i(ready), .rsp_valid_i(rv), .rsp_data_i(dat),
    .rsp_err_i(err), .valid_o(valid), .op_o(op), .ok_o(ok), .data_o(data));
  function automatic rom_pkg::rom_err_t xe(input logic k, input logic f);
    return !k ? `ROM_ERR_TYPE : f ? `ROM_ERR_SPECIFIC : `ROM_ERR_NONE;
  endfunction : xe
  task automatic act(input rom_pkg::rom_op_t a, input logic b, input logic [7:0] c);
    rom_gw_model_inst.exec(a, b, c, $urandom_range(2), rd, re, to);
    if (b && a == `ROM_OP_SET_OUTPUTS) xd = c;
    if (to) begin fail_count++; close_out(); end
  endtask : act
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    void'($urandom(32'h7F55));
    repeat (3) @(posedge clk_i);
    #1 srst_i = 0;
    `CHK(drv, `ROM_STATES_RST)
    `CHK(st, 4'h4)
    act(`ROM_OP_GET_OUTPUTS, 1, 8'h00);
    `CHK(rd, `ROM_STATES_RST)
    act(`ROM_OP_SET_OUTPUTS, 1, 8'h80);
    `CHK(drv, 8'h80)
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      o = 3'($urandom_range(7, 1)); k = ($urandom_range(3) != 0); d = 8'($urandom);
      act(o, k, d);
      `CHK(re, xe(k, 0))
      `CHK(drv, xd)
      if (k && o == `ROM_OP_GET_OUTPUTS) `CHK(rd, xd)
      else if (!k || o != `ROM_OP_GET_INPUTS) `CHK(rd, 8'h00)
    end
    $display("test random done");
    #1 mask = 8'h81;
    repeat (SMP + 2) @(posedge clk_i);
    act(`ROM_OP_GET_INPUTS, 1, 8'h00);
    `CHK(rd, xd ^ 8'h81)
    `CHK(re, xe(1, 1))
    #1 mask = 8'h00;
    repeat (SMP + 2) @(posedge clk_i);
    act(`ROM_OP_CLEAR_FLAGS, 1, 8'h00);
    act(`ROM_OP_GET_STATUS, 1, 8'h00);
    `CHK(re, xe(1, 0))
    $display("test fault done");
    #1 strm = 1; cerr = 1;
    @(posedge clk_i);
    #1 strm = 0; cerr = 0;
    act(`ROM_OP_GET_OUTPUTS, 1, 8'h00);
    `CHK(re, xe(1, 1))
    `CHK(st, 4'hA)
    act(`ROM_OP_CLEAR_FLAGS, 1, 8'h00);
    act(`ROM_OP_GET_STATUS, 1, 8'h00);
    `CHK({re, st}, {xe(1, 0), 4'h0})
    $display("test stream done");
    act(`ROM_OP_SET_OUTPUTS, 1, 8'h5A);
    `CHK(drv, 8'h5A)
    #1 srst_i = 1;
    repeat (3) @(posedge clk_i);
    #1 srst_i = 0;
    xd = `ROM_STATES_RST;
    `CHK({drv, st}, {xd, 4'h4})
    act(`ROM_OP_GET_OUTPUTS, 1, 8'h00);
    `CHK(rd, xd)
    $display("test reset again done");
    close_out();
  end
endmodule : tb_top
bind rom_relay_monitor rom_relay_monitor_sva #(.N(N)) rom_relay_monitor_sva_inst (.clk_i, .srst_i,
  .act_valid_i, .act_ready_o, .act_type_ok_i, .act_op_i, .act_data_i, .rsp_data_o, .coil_mon_i,
  .relay_drive_o, .rsp_valid_o, .stream_err_i, .link_comm_err_i, .rsp_err_o, .rsp_status_o);
`default_nettype wire
